// ==== pgr_regs.sv ====
// module: protected rail-good and buck-1 register slice with rail-good pin delay
`timescale 1ns/1ns
// How it works
// - key register clears after the following transaction
// - key 0x7D opens the next access only, if it is a write
// - any other key keeps registers locked
// - control and buck-1 registers are protected
// - linreg3 good in status bit 6
// - linreg4 good in status bit 5
// - bucks 1..3 good in bits 4..2
// - linregs 1,2 in bits 1,0; bit7 zero
// - control bit 3 masks linreg1 from pin
// - control bit 2 masks linreg2 from pin
// - bits 1..0 select 20/100/200/400 ms delay
// - control resets to 0x0C, upper nibble zero
// - buck-1 bit 7 selects external adjust
// - buck-1 code bits 5..0, lsb fixed
// - status resets zero and is read-only
module pgr_regs #(
  parameter int DLY_SEL0_CYC = pgr_pkg::DLY_SEL0_MS * pgr_pkg::CLK_MHZ * 1000,
  parameter int DLY_SEL1_CYC = pgr_pkg::DLY_SEL1_MS * pgr_pkg::CLK_MHZ * 1000,
  parameter int DLY_SEL2_CYC = pgr_pkg::DLY_SEL2_MS * pgr_pkg::CLK_MHZ * 1000,
  parameter int DLY_SEL3_CYC = pgr_pkg::DLY_SEL3_MS * pgr_pkg::CLK_MHZ * 1000
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire pgr_pkg::pgr_access_type i_acc,           // one-cycle access strobe
  input  wire logic                   i_xfer_done,      // bus transaction finished, pulse
  input  wire pgr_pkg::pgr_rails_type i_rails,          // async rail conditions
  output logic [7:0]                  o_rdata,          // read data, registered
  output logic                        o_rail_good_pin_oe, // high: pin pulled low
  output logic                        o_rail_good_pin,  // pin level driven (always 0)
  output logic                        o_buck1_external_adjust,
  output logic [5:0]                  o_buck1_voltage_code,
  output logic [11:0]                 o_buck1_millivolts // decoded target
);

  // register state
  logic [7:0]  unlock_key_q;        // key register
  logic        armed_q;             // key seen, next write may hit protected reg
  logic [7:0]  ctl_q;               // rail-good control
  logic [7:0]  buck_q;              // buck-1 voltage control
  logic [6:0]  rails_meta_q;        // first synchroniser stage
  logic [6:0]  rails_q;             // second stage, safe to use
  logic [7:0]  status;              // assembled status byte
  logic        all_good;            // all three bucks and unmasked linreg1/linreg2 good; linreg3/linreg4 not included
  logic [26:0] dly_cnt_q;           // pin delay counter
  logic [26:0] dly_target;          // selected delay in cycles
  logic        pin_good_q;          // pin released
  logic        wr_protected;        // write lands on protected register

  // millivolt decode of a buck voltage code
  function automatic logic [11:0] code_to_mv(input logic [5:0] c);
    logic [11:0] mv;
    mv = 12'd0;
    unique case (c[5:4])
      2'b00: mv = 12'(900 + 25 * int'(c[3:0]));             // 0.9 V up in 25 mV
      2'b01: mv = 12'(1300 + 25 * int'(c[3:0]));
      2'b10: mv = 12'(1900 + 50 * int'(c[3:0]));
      2'b11: begin
        if (c[3]) begin
          mv = 12'd3300;                                      // saturates
        end else if (c[2:0] > 3'd4) begin
          mv = 12'(3000 + 100 * (int'(c[2:0]) - 5));         // 3.0 V and up
        end else begin
          mv = 12'(2700 + 50 * int'(c[2:0]));
        end
      end
    endcase
    return mv;
  endfunction

  // two-flop synchroniser for analog good flags
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rails_meta_q <= 7'h00;
      rails_q      <= 7'h00;
    end else begin
      rails_meta_q <= i_rails;
      rails_q      <= rails_meta_q;
    end
  end

  // status byte: read-only, bit 7 reserved
  always_comb begin
    status = pgr_pkg::RST_GOOD_STATUS;
    status[pgr_pkg::ST_LINREG3] = rails_q[6];
    status[pgr_pkg::ST_LINREG4] = rails_q[5];
    status[pgr_pkg::ST_BUCK1]   = rails_q[4];
    status[pgr_pkg::ST_BUCK2]   = rails_q[3];
    status[pgr_pkg::ST_BUCK3]   = rails_q[2];
    status[pgr_pkg::ST_LINREG1] = rails_q[1];
    status[pgr_pkg::ST_LINREG2] = rails_q[0];
  end

  // protected write only when armed by the exact key
  assign wr_protected = i_acc.wr && armed_q &&
                        (i_acc.addr == pgr_pkg::ADDR_GOOD_CONTROL ||
                         i_acc.addr == pgr_pkg::ADDR_BUCK1_VOLT);

  // key register and arm flag; the next access other than a code key write disarms
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      unlock_key_q <= pgr_pkg::RST_UNLOCK_KEY;
      armed_q      <= 1'b0;
    end else if (i_acc.wr && i_acc.addr == pgr_pkg::ADDR_UNLOCK_KEY) begin
      unlock_key_q <= i_acc.wdata;
      armed_q      <= (i_acc.wdata == pgr_pkg::UNLOCK_CODE);
    end else if (i_acc.wr || i_acc.rd) begin
      armed_q      <= 1'b0;                                   // only one write window
    end else if (i_xfer_done && !armed_q) begin
      unlock_key_q <= pgr_pkg::RST_UNLOCK_KEY;
    end
  end

  // protected registers; reserved and fixed bits never change
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctl_q  <= pgr_pkg::RST_GOOD_CONTROL;
      buck_q <= pgr_pkg::RST_BUCK1_VOLT;
    end else if (wr_protected) begin
      if (i_acc.addr == pgr_pkg::ADDR_GOOD_CONTROL) begin
        ctl_q <= i_acc.wdata & pgr_pkg::CTL_WRITE_MASK;
      end else begin
        buck_q <= (i_acc.wdata & pgr_pkg::BUCK_WRITE_MASK) |
                  (pgr_pkg::RST_BUCK1_VOLT & ~pgr_pkg::BUCK_WRITE_MASK);
      end
    end
  end

  // read data; unmapped reads return zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_acc.rd) begin
      unique case (i_acc.addr)
        pgr_pkg::ADDR_UNLOCK_KEY:   o_rdata <= unlock_key_q;
        pgr_pkg::ADDR_GOOD_STATUS:  o_rdata <= status;
        pgr_pkg::ADDR_GOOD_CONTROL: o_rdata <= ctl_q;
        pgr_pkg::ADDR_BUCK1_VOLT:   o_rdata <= buck_q;
        default:                    o_rdata <= 8'h00;
      endcase
    end
  end

  // bucks and unmasked linreg1/linreg2 combine into the pin condition; linreg3/linreg4 are left out
  assign all_good = rails_q[4] && rails_q[3] && rails_q[2] &&
                    (rails_q[1] || ctl_q[pgr_pkg::CTL_LINREG1_MASK_BIT]) &&
                    (rails_q[0] || ctl_q[pgr_pkg::CTL_LINREG2_MASK_BIT]);

  // delay select
  always_comb begin
    unique case (ctl_q[1:0])
      2'b00: dly_target = 27'(DLY_SEL0_CYC);
      2'b01: dly_target = 27'(DLY_SEL1_CYC);
      2'b10: dly_target = 27'(DLY_SEL2_CYC);
      2'b11: dly_target = 27'(DLY_SEL3_CYC);
    endcase
  end

  // pin release after delay, immediate drop whenever all_good goes low
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dly_cnt_q  <= 27'd0;
      pin_good_q <= 1'b0;
    end else if (!all_good) begin
      dly_cnt_q  <= 27'd0;
      pin_good_q <= 1'b0;
    end else if (dly_cnt_q >= dly_target - 27'd1) begin
      pin_good_q <= 1'b1;
    end else begin
      dly_cnt_q  <= dly_cnt_q + 27'd1;
    end
  end

  // open-drain: drive low unless released
  assign o_rail_good_pin_oe = !pin_good_q;
  assign o_rail_good_pin    = 1'b0;

  // buck-1 outputs: source select and code
  assign o_buck1_external_adjust = buck_q[pgr_pkg::BUCK_EXT_ADJ_BIT];
  assign o_buck1_voltage_code    = buck_q[5:0];
  assign o_buck1_millivolts      = code_to_mv(buck_q[5:0]);

  // assertions: each guards one rule, gathered here after the logic they watch; all run
  // on the system clock and are silenced while reset is high
  // they look at registers, decoded nets and the access inputs only, never at the raw rail
  // inputs, so metastable samples cannot trip them
  
  // millivolt ceiling of the top code range; codes above it clamp here
  localparam logic [11:0] MV_CEILING = 12'hCE4;

  // key write carrying the opening code
  sequence s_key_code_write;
    i_acc.wr && i_acc.addr == pgr_pkg::ADDR_UNLOCK_KEY &&
    i_acc.wdata == pgr_pkg::UNLOCK_CODE;
  endsequence

  // key write carrying any other value, reset value included
  sequence s_key_other_write;
    i_acc.wr && i_acc.addr == pgr_pkg::ADDR_UNLOCK_KEY &&
    i_acc.wdata != pgr_pkg::UNLOCK_CODE;
  endsequence

  // armed write aimed at the control register
  sequence s_armed_ctl_write;
    armed_q && i_acc.wr && i_acc.addr == pgr_pkg::ADDR_GOOD_CONTROL;
  endsequence

  // armed write aimed at the buck-1 register
  sequence s_armed_buck_write;
    armed_q && i_acc.wr && i_acc.addr == pgr_pkg::ADDR_BUCK1_VOLT;
  endsequence

  // protected registers only change in the cycle after an armed state
  // a stray write while locked would show up here as a change
  a_lock_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!armed_q) |=> ($stable(ctl_q) && $stable(buck_q)))
    else $error("protected register changed while locked");

  // key write of the code arms exactly one cycle later
  // step one of the two-step unlock
  a_key_arms: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_key_code_write |=> armed_q)
    else $error("unlock code did not arm");

  // a wrong key never opens the window
  // near-miss codes are the likeliest host slip
  a_wrong_key: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_key_other_write |=> !armed_q)
    else $error("wrong key armed the window");

  // any later access other than a key write disarms
  a_one_shot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (armed_q && (i_acc.rd || (i_acc.wr && i_acc.addr != pgr_pkg::ADDR_UNLOCK_KEY)))
    |=> !armed_q)
    else $error("unlock window stayed open");

  // the window waits for the next access, however long the host idles
  // the arming transaction's own end pulse must not close it
  a_window_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (armed_q && !i_acc.wr && !i_acc.rd) |=> (armed_q && $stable(unlock_key_q)))
    else $error("unlock window closed while idle");

  // key clears after completed transaction
  // only once the window has been used or abandoned
  a_key_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_xfer_done && !armed_q && !i_acc.wr && !i_acc.rd) |=>
    unlock_key_q == pgr_pkg::RST_UNLOCK_KEY)
    else $error("key did not clear");

  // key changes only by a key write or a transaction end
  // nothing else may disturb it mid-transaction
  a_key_steady: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!i_xfer_done && !(i_acc.wr && i_acc.addr == pgr_pkg::ADDR_UNLOCK_KEY)) |=>
    $stable(unlock_key_q))
    else $error("key changed without cause");

  // armed control write lands with reserved bits cleared
  // step two of the unlock, control target
  a_ctl_lands: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_armed_ctl_write |=> ctl_q == ($past(i_acc.wdata) & pgr_pkg::CTL_WRITE_MASK))
    else $error("unlocked control write lost");

  // armed buck write takes source select and upper code bits
  // step two of the unlock, buck-1 target
  a_buck_lands: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_armed_buck_write |=> (buck_q[5:1] == $past(i_acc.wdata[5:1]) &&
                            buck_q[7] == $past(i_acc.wdata[7])))
    else $error("unlocked buck write lost");

  // reserved bits stay zero
  a_ctl_reserved: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctl_q[7:4] == 4'h0 && buck_q[6] == 1'b0 && buck_q[0] == 1'b0)
    else $error("reserved bit set");

  // status follows synchronised rails, bit 7 zero
  a_status_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    status == {1'b0, rails_q})
    else $error("status map wrong");

  // a status read returns the byte assembled at the taking edge
  // writes to the status address must leave this untouched
  a_status_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_acc.rd && i_acc.addr == pgr_pkg::ADDR_GOOD_STATUS) |=> o_rdata == $past(status))
    else $error("status read wrong");

  // read data stands between reads
  // hosts that sample late still see the right byte
  a_rdata_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!i_acc.rd) |=> $stable(o_rdata))
    else $error("read data moved without a read");

  // failing unmasked buck drops pin next cycle
  a_pin_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!rails_q[4]) |=> o_rail_good_pin_oe)
    else $error("pin not pulled low");

  // the other two bucks can never be masked either
  // they share the same single-cycle drop path
  a_pin_drop_bucks: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!rails_q[3] || !rails_q[2]) |=> o_rail_good_pin_oe)
    else $error("buck failure did not drop pin");

  // a drop after release restarts the delay from zero
  // so a glitching rail cannot ride on an earlier partial count
  a_drop_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (pin_good_q && !all_good) |=> (o_rail_good_pin_oe && dly_cnt_q == 27'd0))
    else $error("delay not restarted after drop");

  // unmasked linreg1 low keeps pin low
  a_mask_ldo1: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!ctl_q[pgr_pkg::CTL_LINREG1_MASK_BIT] && !rails_q[1]) |=> o_rail_good_pin_oe)
    else $error("linreg1 not honoured");

  // unmasked linreg2 low keeps pin low
  a_mask_ldo2: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!ctl_q[pgr_pkg::CTL_LINREG2_MASK_BIT] && !rails_q[0]) |=> o_rail_good_pin_oe)
    else $error("linreg2 not honoured");

  // no release before the count completes
  a_no_early: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(pin_good_q) |-> dly_cnt_q >= dly_target - 27'd1)
    else $error("pin released early");

  // release only follows a cycle with all bucks and unmasked linreg1/linreg2 good
  // a late failure in the last counting cycle must win
  a_release_good: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(pin_good_q) |-> $past(all_good))
    else $error("pin released on a bad rail");

  // once released, the pin stays released while rails hold good
  // a select change after release must not pull it low again
  a_stay_released: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (pin_good_q && all_good) |=> pin_good_q)
    else $error("pin dropped with all rails good");

  // open-drain only ever drives low
  a_pin_level: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_rail_good_pin == 1'b0)
    else $error("pin driven high");

  // top codes saturate at the ceiling
  // every code from the first saturating one upward reads the same
  a_code_ceiling: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (buck_q[5:3] == 3'b111) |-> o_buck1_millivolts == MV_CEILING)
    else $error("top code not saturated");

endmodule

// ==== pgr_pkg.sv ====
// package: register map, field layout, reset values and timing for the rail-good register slice
package pgr_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_UNLOCK_KEY   = 8'h0B;
  localparam logic [7:0] ADDR_GOOD_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_GOOD_CONTROL = 8'h0D;
  localparam logic [7:0] ADDR_BUCK1_VOLT   = 8'h0E;

  // reset values
  localparam logic [7:0] RST_UNLOCK_KEY    = 8'h00;
  localparam logic [7:0] RST_GOOD_STATUS   = 8'h00;
  localparam logic [7:0] RST_GOOD_CONTROL  = 8'h0C;
  localparam logic [7:0] RST_BUCK1_VOLT    = 8'h18;

  // the single code that opens protected registers
  localparam logic [7:0] UNLOCK_CODE       = 8'h7D;

  // field positions in the control register
  localparam int CTL_LINREG1_MASK_BIT      = 3;
  localparam int CTL_LINREG2_MASK_BIT      = 2;
  // writable bits: masks and delay select; upper nibble reserved
  localparam logic [7:0] CTL_WRITE_MASK    = 8'h0F;
  // buck-1: bit 7 external adjust, bit 6 reserved, bits 5..1 writable, bit 0 fixed
  localparam int BUCK_EXT_ADJ_BIT          = 7;
  localparam logic [7:0] BUCK_WRITE_MASK   = 8'hBE;

  // status bit positions
  localparam int ST_LINREG3 = 6;
  localparam int ST_LINREG4 = 5;
  localparam int ST_BUCK1   = 4;
  localparam int ST_BUCK2   = 3;
  localparam int ST_BUCK3   = 2;
  localparam int ST_LINREG1 = 1;
  localparam int ST_LINREG2 = 0;

  // delay choices in milliseconds
  localparam int DLY_SEL0_MS = 20;
  localparam int DLY_SEL1_MS = 100;
  localparam int DLY_SEL2_MS = 200;
  localparam int DLY_SEL3_MS = 400;
  localparam int CLK_MHZ     = 250;

  // rail condition inputs from the analog side
  typedef struct packed {
    logic linreg3_good;
    logic linreg4_good;
    logic buck1_good;
    logic buck2_good;
    logic buck3_good;
    logic linreg1_good;
    logic linreg2_good;
  } pgr_rails_type;

  // one register-port access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgr_access_type;

endpackage

// ==== pgr_host.sv ====
// host model: register-port master, one access per bus transaction
`timescale 1ns/1ns
module pgr_host (
  input  wire logic                    i_clk_sys,
  input  wire logic [7:0]              i_rdata,
  output pgr_pkg::pgr_access_type      o_acc,
  output logic                         o_xfer_done
);
  // idle port at time zero
  initial begin
    o_acc = '0;
    o_xfer_done = 1'h0;
  end
  // one access, then the end-of-transaction pulse; changes only at falling edges
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_acc = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_clk_sys);
    o_acc = '0;
    o_xfer_done = 1'h1;
    @(negedge i_clk_sys);
    o_xfer_done = 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask
  // read data is registered at the taking edge and holds, so sample afterwards
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'h0, a, 8'h00);
    q = i_rdata;
  endtask
  // key write, then the single protected write straight after it
  task automatic unlock_wr(input logic [7:0] a, input logic [7:0] d);
    wr(pgr_pkg::ADDR_UNLOCK_KEY, pgr_pkg::UNLOCK_CODE);
    wr(a, d);
  endtask
endmodule

// ==== pgr_regs_test.sv ====
// self-checking bench for the rail-good register slice
`timescale 1ns/1ns
module pgr_regs_test;
  logic                    i_clk_sys = 1'h0;
  logic                    i_rst = 1'h1;
  pgr_pkg::pgr_access_type acc;
  pgr_pkg::pgr_rails_type  rails = '0;
  logic                    xfer_done, pin_oe, pin, adj;
  logic [7:0]              rdata, q;
  logic [5:0]              code;
  logic [11:0]             mv;
  logic [7:0]              keys [4] = '{8'h00, 8'h7C, 8'h7E, 8'hFF};
  logic [7:0]              bw [4] = '{8'hFF, 8'h20, 8'h11, 8'hB1};
  logic [11:0]             bmv [4] = '{12'hCE4, 12'h76C, 12'h514, 12'hA8C};
  int                      n_fail = 0;
  int                      cmp_count = 0;
  int                      n;
  always #2 i_clk_sys = ~i_clk_sys;
  // delays shortened to 8 << select so the run stays short
  pgr_regs #(.DLY_SEL0_CYC(8), .DLY_SEL1_CYC(16), .DLY_SEL2_CYC(32), .DLY_SEL3_CYC(64)) dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_acc(acc), .i_xfer_done(xfer_done),
    .i_rails(rails), .o_rdata(rdata), .o_rail_good_pin_oe(pin_oe), .o_rail_good_pin(pin),
    .o_buck1_external_adjust(adj), .o_buck1_voltage_code(code), .o_buck1_millivolts(mv));
  pgr_host host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_acc(acc), .o_xfer_done(xfer_done));
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, q);
    chk($sformatf("register %h", a), {4'h0, q}, {4'h0, exp});
  endtask
  // wait some cycles, then look at the open-drain enable
  task automatic pin_after(input int c, input logic exp);
    repeat (c) @(negedge i_clk_sys);
    chk("pin enable", {11'h000, pin_oe}, {11'h000, exp});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'h0;
    // reset values, unmapped address, outputs
    rchk(pgr_pkg::ADDR_UNLOCK_KEY, 8'h00);
    rchk(pgr_pkg::ADDR_GOOD_STATUS, 8'h00);
    rchk(pgr_pkg::ADDR_GOOD_CONTROL, 8'h0C);
    rchk(pgr_pkg::ADDR_BUCK1_VOLT, 8'h18);
    rchk(8'h20, 8'h00);
    chk("adjust", {11'h000, adj}, 12'h000);
    chk("code", {6'h00, code}, 12'h018);
    pin_after(1, 1'h1);
    chk("pin level", {11'h000, pin}, 12'h000);
    $display("reset test done");
    // wrong keys leave both protected registers locked
    foreach (keys[i]) begin
      host.wr(pgr_pkg::ADDR_UNLOCK_KEY, keys[i]);
      host.wr(pgr_pkg::ADDR_GOOD_CONTROL, 8'h01);
      rchk(pgr_pkg::ADDR_GOOD_CONTROL, 8'h0C);
      host.wr(pgr_pkg::ADDR_BUCK1_VOLT, 8'h00);
      rchk(pgr_pkg::ADDR_BUCK1_VOLT, 8'h18);
    end
    // one write after the key, then locked again; key clears afterwards
    host.unlock_wr(pgr_pkg::ADDR_GOOD_CONTROL, 8'hF1);
    rchk(pgr_pkg::ADDR_GOOD_CONTROL, 8'h01);
    host.wr(pgr_pkg::ADDR_GOOD_CONTROL, 8'h02);
    rchk(pgr_pkg::ADDR_GOOD_CONTROL, 8'h01);
    rchk(pgr_pkg::ADDR_UNLOCK_KEY, 8'h00);
    // a read between key and write disarms, and its transaction clears the key
    host.wr(pgr_pkg::ADDR_UNLOCK_KEY, pgr_pkg::UNLOCK_CODE);
    rchk(pgr_pkg::ADDR_UNLOCK_KEY, 8'h7D);
    host.wr(pgr_pkg::ADDR_BUCK1_VOLT, 8'h00);
    rchk(pgr_pkg::ADDR_BUCK1_VOLT, 8'h18);
    rchk(pgr_pkg::ADDR_UNLOCK_KEY, 8'h00);
    $display("lock test done");
    // buck-1 fields and decoded voltage
    foreach (bw[i]) begin
      host.unlock_wr(pgr_pkg::ADDR_BUCK1_VOLT, bw[i]);
      rchk(pgr_pkg::ADDR_BUCK1_VOLT, bw[i] & 8'hBE);
      chk("adjust", {11'h000, adj}, {11'h000, bw[i][7]});
      chk("code", {6'h00, code}, {6'h00, bw[i][5:1], 1'h0});
      chk("millivolts", mv, bmv[i]);
    end
    $display("buck test done");
    // each rail lands on its own status bit; writes to status ignored
    for (int b = 0; b < 7; b++) begin
      @(negedge i_clk_sys);
      rails = pgr_pkg::pgr_rails_type'(7'h01 << b);
      pin_after(4, 1'h1);
      rchk(pgr_pkg::ADDR_GOOD_STATUS, 8'h01 << b);
    end
    host.wr(pgr_pkg::ADDR_GOOD_STATUS, 8'hFF);
    rchk(pgr_pkg::ADDR_GOOD_STATUS, 8'h40);
    $display("status test done");
    // release delay for every select, then an immediate drop
    for (int s = 0; s < 4; s++) begin
      host.unlock_wr(pgr_pkg::ADDR_GOOD_CONTROL, {6'h03, s[1:0]});
      rails = pgr_pkg::pgr_rails_type'(7'h7F);
      n = 0;
      while (pin_oe === 1'h1 && n < 200) begin
        @(negedge i_clk_sys);
        n++;
      end
      chk("release delay", {11'h000, n >= (8 << s) && n <= (8 << s) + 6}, 12'h001);
      if (n >= 200) test_done();
      rails.buck1_good = 1'h0;
      pin_after(4, 1'h1);
      // buck1 stays low until the next select is written, so no count runs early
    end
    // masks: linreg2 bad, then linreg1 bad
    host.unlock_wr(pgr_pkg::ADDR_GOOD_CONTROL, 8'h0C);
    rails = pgr_pkg::pgr_rails_type'(7'h7E);
    pin_after(20, 1'h0);
    host.unlock_wr(pgr_pkg::ADDR_GOOD_CONTROL, 8'h08);
    pin_after(6, 1'h1);
    host.unlock_wr(pgr_pkg::ADDR_GOOD_CONTROL, 8'h04);
    pin_after(20, 1'h0);
    rails = pgr_pkg::pgr_rails_type'(7'h7D);
    pin_after(6, 1'h1);
    host.unlock_wr(pgr_pkg::ADDR_GOOD_CONTROL, 8'h08);
    pin_after(20, 1'h0);
    $display("pin test done");
    test_done();
  end
endmodule
